// [rtl/tdc_pkg.sv]
// package: constants, states and carrier types of the transceiver control
package tdc_pkg;
	// clock period of CLOCK in ns, taken as the crystal reference
	localparam int CLK_PERIOD_NS = 40;
	// data clock dividers by band bit 0, digital clock is half
	localparam int DIV_DATA_B0 = 60;
	localparam int DIV_DATA_B1 = 80;
	localparam int DIV_DIG_B0 = DIV_DATA_B0 / 2;
	localparam int DIV_DIG_B1 = DIV_DATA_B1 / 2;
	// if filter reference dividers by band bit 0
	localparam int DIV_IF_B0 = 9;
	localparam int DIV_IF_B1 = 12;
	// nominal manchester half-bit length in digital clock ticks per range
	localparam logic [7:0] HALF_BIT_R0 = 8'h3C;
	localparam logic [7:0] HALF_BIT_R1 = 8'h1E;
	localparam logic [7:0] HALF_BIT_R2 = 8'h0F;
	localparam logic [7:0] HALF_BIT_R3 = 8'h08;
	// reset values
	localparam logic [15:0] SYNTH_RST = 16'h0000;
	localparam logic [1:0] STEP_RST = 2'h0;
	// synchronised pin positions
	localparam int PIN_LOWV = 0;
	localparam int PIN_LOCK = 1;
	localparam int PIN_SHAPE = 2;
	localparam int PIN_TXD = 3;
	localparam int PIN_WAKE = 4;
	localparam int NUM_PINS = 5;

	typedef enum logic [1:0] {
		ST_RX,
		ST_TX,
		ST_STANDBY,
		ST_MONITOR
	} tdc_mode_t;

	// one bank of configuration
	typedef struct packed {
		logic        freq_shift_mode;
		logic        dme;
		logic [1:0]  rate;
		logic [1:0]  lpf_bw;
		logic [1:0]  lna_step;
		logic [1:0]  pa_step;
		logic        adaptive;
		logic [15:0] carrier;
	} tdc_cfg_t;

	// synthesizer words written by the host in direct method
	typedef struct packed {
		logic [15:0] rx;
		logic [15:0] tx_lo;
		logic [15:0] tx_hi;
	} tdc_direct_t;
endpackage

// [rtl/tdc_top.sv]
// transceiver digital control: reset, low-voltage, rx data, tx keying
`timescale 1ns/1ps

// Overview of operation
// RL1 - power-on reset returns every register to its default value
// RL2 - with monitor enabled, supply below 1.8 V sets the low-voltage flag
// RL3 - low-voltage flag stays latched until a read of it clears it
// RL4 - standby request with monitor enabled gives monitoring mode, not standby
// RL5 - data manager recovers clock, decodes manchester, presents data and clock
// RL6 - without data manager, shaped demodulated data goes straight out
// RL7 - configuration selects data-rate range and receive low-pass bandwidth
// RL8 - received data is discarded while the synthesizer is out of lock
// RL9 - loss of lock during transmit stops the carrier
// RL10 - rf switch output toggles on every rx-to-tx and tx-to-rx change
// RL11 - amplitude mode keys the carrier on and off from host coded data
// RL12 - frequency mode shifts the synthesizer word by the deviation from data
// RL13 - two banks, loaded at strobe wakeup or on host command
// RL14 - data clock divides by 60 or 80, digital clock by half that
// RL15 - if filter reference divides by 9 or 12 from band bit 0
// RL16 - friendly method computes synthesizer words from carrier and deviation
// RL17 - direct method takes all three synthesizer words from the host
// RL18 - receiver front-end gain has four programmable reduction steps
// RL19 - transmit power has four programmable reduction steps
// RL20 - threshold fixed or adaptive; frequency mode always adaptive
// RL21 - configuration is retained in standby
module tdc_top (
	// clock and power-on reset
	input  wire logic                 CLOCK,
	input  wire logic                 RESETN,
	// mode and monitor control
	input  wire logic                 LOWVOLT_MONITOR_ENABLE,
	input  wire logic                 STANDBY_REQ,
	input  wire logic                 TX_REQ,
	input  wire logic                 LOWVOLT_READ,
	input  wire logic [1:0]           BAND_SELECT_BITS,
	// configuration banks and frequency words
	input  wire tdc_pkg::tdc_cfg_t    CFG_BANK_A,
	input  wire tdc_pkg::tdc_cfg_t    CFG_BANK_B,
	input  wire logic                 BANK_A_EN,
	input  wire logic                 BANK_B_EN,
	input  wire logic                 BANK_SWITCH_CMD,
	input  wire logic                 DIRECT_METHOD,
	input  wire logic [7:0]           DEVIATION_WORD,
	input  wire tdc_pkg::tdc_direct_t DIRECT_WORDS,
	// asynchronous pins
	input  wire logic                 LOWVOLT_CMP,
	input  wire logic                 PLL_LOCK,
	input  wire logic                 RX_SHAPED,
	input  wire logic                 TX_DATA,
	input  wire logic                 WAKEUP_STROBE,
	// decoded data handshake
	input  wire logic                 RX_BIT_READY,
	output logic                      RX_BIT,
	output logic                      RX_BIT_VALID,
	output logic                      RX_BIT_CLK,
	output logic                      RX_OVERRUN,
	output logic                      RX_RAW,
	// status and analog control
	output logic                      LOWVOLT_STATUS,
	output logic                      MONITOR_MODE,
	output logic                      STANDBY_ACTIVE,
	output logic                      BANK_STATUS,
	output logic                      RF_SWITCH,
	output logic                      PA_ON,
	output logic [15:0]               SYNTH_WORD,
	output logic [1:0]                LNA_STEP,
	output logic [1:0]                PA_STEP,
	output logic [1:0]                LPF_BW,
	output logic                      THRESH_ADAPTIVE,
	output logic                      DATA_CLK_EN,
	output logic                      DIG_CLK_EN,
	output logic                      IF_REF_TOGGLE
);
	import tdc_pkg::*;

	// pick a divider by band bit 0
	function automatic logic [6:0] band_div(input logic b0, input int lo,
		input int hi);
		band_div = b0 ? 7'(hi - 1) : 7'(lo - 1);
	endfunction

	// three-stage synchronisers, value moves when stage two and three agree
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] pin_s1_q;
	logic [NUM_PINS-1:0] pin_s2_q;
	logic [NUM_PINS-1:0] pin_s3_q;
	logic [NUM_PINS-1:0] pin_q;
	assign pin_raw = {WAKEUP_STROBE, TX_DATA, RX_SHAPED, PLL_LOCK,
		LOWVOLT_CMP};
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
			always_ff @(posedge CLOCK or negedge RESETN) begin
				if (!RESETN) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
					pin_s3_q[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
					pin_s3_q[gi] <= pin_s2_q[gi];
					if (pin_s2_q[gi] == pin_s3_q[gi])
						pin_q[gi] <= pin_s3_q[gi];
				end
			end
		end
	endgenerate
	wire lowv_f = pin_q[PIN_LOWV];
	wire lock_f = pin_q[PIN_LOCK];
	wire shape_f = pin_q[PIN_SHAPE];
	wire txd_f = pin_q[PIN_TXD];
	wire wake_f = pin_q[PIN_WAKE];

	// clock dividers from the reference, selected by band bit 0
	logic [6:0] data_cnt_q, dig_cnt_q, if_cnt_q;
	logic       data_en_q, dig_en_q, if_tog_q;
	wire [6:0] data_top = band_div(BAND_SELECT_BITS[0], DIV_DATA_B0,
		DIV_DATA_B1); // RL14
	wire [6:0] dig_top = band_div(BAND_SELECT_BITS[0], DIV_DIG_B0,
		DIV_DIG_B1); // RL14
	wire [6:0] if_top = band_div(BAND_SELECT_BITS[0], DIV_IF_B0,
		DIV_IF_B1); // RL15
	// a band change mid-count wraps at once rather than overshooting
	wire data_wrap = (data_cnt_q >= data_top);
	wire dig_wrap = (dig_cnt_q >= dig_top);
	wire if_wrap = (if_cnt_q >= if_top);
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			data_cnt_q <= 7'h00;
			dig_cnt_q <= 7'h00;
			if_cnt_q <= 7'h00;
			data_en_q <= 1'b0;
			dig_en_q <= 1'b0;
			if_tog_q <= 1'b0;
		end else begin
			data_cnt_q <= data_wrap ? 7'h00 : data_cnt_q + 7'h01;
			dig_cnt_q <= dig_wrap ? 7'h00 : dig_cnt_q + 7'h01;
			if_cnt_q <= if_wrap ? 7'h00 : if_cnt_q + 7'h01;
			data_en_q <= data_wrap;
			dig_en_q <= dig_wrap;
			if_tog_q <= if_tog_q ^ if_wrap; // 1.5/2 scaling is analog
		end
	end

	// bank selection: both enabled alternate, one enabled is fixed
	logic     bank_q;
	logic     wake_prev_q;
	wire      wake_rise = wake_f & ~wake_prev_q;
	wire      bank_both = BANK_A_EN & BANK_B_EN;
	wire      bank_load = bank_both & (wake_rise | BANK_SWITCH_CMD); // RL13
	wire      bank_d = bank_load ? ~bank_q :
		(bank_both ? bank_q : (BANK_B_EN & ~BANK_A_EN));
	tdc_cfg_t cfg_q;
	wire tdc_cfg_t cfg_d = bank_d ? CFG_BANK_B : CFG_BANK_A;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			bank_q <= 1'b0;
			wake_prev_q <= 1'b0;
			cfg_q <= '0; // RL1
		end else begin
			wake_prev_q <= wake_f;
			bank_q <= bank_d;
			cfg_q <= cfg_d; // RL21
		end
	end

	// operating mode
	tdc_mode_t mode_q, mode_d;
	always_comb begin
		if (STANDBY_REQ)
			mode_d = LOWVOLT_MONITOR_ENABLE ? ST_MONITOR : ST_STANDBY; // RL4
		else if (TX_REQ)
			mode_d = ST_TX;
		else
			mode_d = ST_RX;
	end
	wire in_tx = (mode_q == ST_TX);
	wire in_rx = (mode_q == ST_RX);
	wire rxtx_change = (in_rx && mode_d == ST_TX) ||
		(in_tx && mode_d == ST_RX); // RL10

	// low-voltage flag: a set in the read cycle wins over the clear
	logic lvds_q;
	wire  lvds_set = LOWVOLT_MONITOR_ENABLE & lowv_f; // RL2
	wire  lvds_d = lvds_set | (lvds_q & ~LOWVOLT_READ); // RL3

	// mode, switch and flag registers
	logic sw_q, mon_q, stby_q;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			mode_q <= ST_RX;
			sw_q <= 1'b0;
			lvds_q <= 1'b0;
			mon_q <= 1'b0;
			stby_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			sw_q <= sw_q ^ rxtx_change; // RL10
			lvds_q <= lvds_d;
			mon_q <= (mode_d == ST_MONITOR);
			stby_q <= (mode_d == ST_STANDBY);
		end
	end

	// manchester decoder on the digital clock; mid-bit edges beyond
	// 1.5 half-bits since the last one carry data, others are boundaries
	logic [7:0] half_len;
	always_comb begin
		unique case (cfg_q.rate) // RL7
			2'd0: half_len = HALF_BIT_R0;
			2'd1: half_len = HALF_BIT_R1;
			2'd2: half_len = HALF_BIT_R2;
			2'd3: half_len = HALF_BIT_R3;
		endcase
	end
	logic [8:0] run_q;
	logic       shape_prev_q;
	wire [8:0]  mid_thresh = {1'b0, half_len} + {2'b00, half_len[7:1]};
	wire        edge_seen = dig_en_q & (shape_f != shape_prev_q);
	wire        mid_edge = edge_seen & (run_q >= mid_thresh); // RL5
	wire        rx_live = in_rx & cfg_q.dme & lock_f; // RL8
	wire        buf_in_ready;
	wire        push = mid_edge & rx_live & buf_in_ready;
	wire        overrun = mid_edge & rx_live & ~buf_in_ready;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			run_q <= 9'h000;
			shape_prev_q <= 1'b0;
		end else if (dig_en_q) begin
			shape_prev_q <= shape_f;
			if (mid_edge)
				run_q <= 9'h000;
			else if (run_q != 9'h1FF)
				run_q <= run_q + 9'h001;
		end
	end

	// two-entry skid buffer; when full the decoded bit is dropped and overrun flagged
	logic head_q, head_v_q, tail_q, tail_v_q;
	wire  pop = head_v_q & RX_BIT_READY;
	assign buf_in_ready = ~tail_v_q;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			head_q <= 1'b0;
			head_v_q <= 1'b0;
			tail_q <= 1'b0;
			tail_v_q <= 1'b0;
		end else if (pop && tail_v_q) begin
			head_q <= tail_q;
			tail_v_q <= 1'b0;
		end else if (pop) begin
			head_q <= shape_f;
			head_v_q <= push;
		end else if (push && !head_v_q) begin
			head_q <= shape_f;
			head_v_q <= 1'b1;
		end else if (push) begin
			tail_q <= shape_f;
			tail_v_q <= 1'b1;
		end
	end

	// raw path, recovered clock and overrun strobes
	logic raw_q, bclk_q, ovr_q;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			raw_q <= 1'b0;
			bclk_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			raw_q <= in_rx & ~cfg_q.dme & lock_f & shape_f; // RL6 RL8
			bclk_q <= push; // RL5
			ovr_q <= overrun;
		end
	end

	// transmit keying and synthesizer word
	wire        key_on = in_tx & lock_f & (cfg_q.freq_shift_mode | txd_f); // RL9 RL11
	wire [15:0] dev16 = {8'h00, DEVIATION_WORD};
	wire [15:0] fr_tx = txd_f ? cfg_q.carrier + dev16 :
		cfg_q.carrier - dev16; // RL12
	wire [15:0] fr_word = (in_tx && cfg_q.freq_shift_mode) ? fr_tx : cfg_q.carrier; // RL16
	wire [15:0] dr_tx = txd_f ? DIRECT_WORDS.tx_hi : DIRECT_WORDS.tx_lo;
	wire [15:0] dr_word = !in_tx ? DIRECT_WORDS.rx :
		(cfg_q.freq_shift_mode ? dr_tx : DIRECT_WORDS.tx_lo); // RL17
	wire [15:0] synth_d = DIRECT_METHOD ? dr_word : fr_word;
	logic        pa_q, adapt_q;
	logic [15:0] synth_q;
	logic [1:0]  lna_q, pas_q, lpf_q;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			pa_q <= 1'b0;
			synth_q <= SYNTH_RST;
			lna_q <= STEP_RST;
			pas_q <= STEP_RST;
			lpf_q <= STEP_RST;
			adapt_q <= 1'b0;
		end else begin
			pa_q <= key_on;
			synth_q <= synth_d;
			lna_q <= cfg_q.lna_step; // RL18
			pas_q <= cfg_q.pa_step; // RL19
			lpf_q <= cfg_q.lpf_bw; // RL7
			adapt_q <= cfg_q.adaptive | cfg_q.freq_shift_mode; // RL20
		end
	end

	// outputs, all straight from flip-flops
	assign RX_BIT = head_q;
	assign RX_BIT_VALID = head_v_q;
	assign RX_BIT_CLK = bclk_q;
	assign RX_OVERRUN = ovr_q;
	assign RX_RAW = raw_q;
	assign LOWVOLT_STATUS = lvds_q;
	assign MONITOR_MODE = mon_q;
	assign STANDBY_ACTIVE = stby_q;
	assign BANK_STATUS = bank_q;
	assign RF_SWITCH = sw_q;
	assign PA_ON = pa_q;
	assign SYNTH_WORD = synth_q;
	assign LNA_STEP = lna_q;
	assign PA_STEP = pas_q;
	assign LPF_BW = lpf_q;
	assign THRESH_ADAPTIVE = adapt_q;
	assign DATA_CLK_EN = data_en_q;
	assign DIG_CLK_EN = dig_en_q;
	assign IF_REF_TOGGLE = if_tog_q;

	// checks
	property p_lvds_set;
		@(posedge CLOCK) disable iff (!RESETN)
		lvds_set |=> LOWVOLT_STATUS;
	endproperty
	a_lvds_set: assert property (p_lvds_set) // RL2
		else $error("low-voltage flag not set");
	property p_lvds_hold;
		@(posedge CLOCK) disable iff (!RESETN)
		LOWVOLT_STATUS && !LOWVOLT_READ |=> LOWVOLT_STATUS;
	endproperty
	a_lvds_hold: assert property (p_lvds_hold) // RL3
		else $error("low-voltage flag dropped without read");
	property p_no_standby;
		@(posedge CLOCK) disable iff (!RESETN)
		STANDBY_REQ && LOWVOLT_MONITOR_ENABLE |=>
			MONITOR_MODE && !STANDBY_ACTIVE;
	endproperty
	a_no_standby: assert property (p_no_standby) // RL4
		else $error("standby entered with monitor on");
	property p_switch;
		@(posedge CLOCK) disable iff (!RESETN)
		rxtx_change |=> RF_SWITCH != $past(RF_SWITCH);
	endproperty
	a_switch: assert property (p_switch) // RL10
		else $error("rf switch did not toggle");
	property p_unlock_tx;
		@(posedge CLOCK) disable iff (!RESETN)
		!lock_f |=> !PA_ON;
	endproperty
	a_unlock_tx: assert property (p_unlock_tx) // RL9
		else $error("carrier on while unlocked");
	property p_unlock_rx;
		@(posedge CLOCK) disable iff (!RESETN)
		!lock_f |=> !RX_BIT_CLK && !RX_RAW;
	endproperty
	a_unlock_rx: assert property (p_unlock_rx) // RL8
		else $error("data delivered while unlocked");
	property p_ook;
		@(posedge CLOCK) disable iff (!RESETN)
		in_tx && lock_f && !cfg_q.freq_shift_mode |=> PA_ON == $past(txd_f);
	endproperty
	a_ook: assert property (p_ook) // RL11
		else $error("carrier not keyed by data");
	property p_raw;
		@(posedge CLOCK) disable iff (!RESETN)
		in_rx && !cfg_q.dme && lock_f |=> RX_RAW == $past(shape_f);
	endproperty
	a_raw: assert property (p_raw) // RL6
		else $error("raw data path wrong");
	sequence s_data_gap;
		data_en_q ##1 !data_en_q [*8];
	endsequence
	property p_data_div;
		@(posedge CLOCK) disable iff (!RESETN)
		data_en_q && $stable(BAND_SELECT_BITS) |-> s_data_gap;
	endproperty
	a_data_div: assert property (p_data_div) // RL14
		else $error("data clock enable too frequent");
	property p_bank;
		@(posedge CLOCK) disable iff (!RESETN)
		bank_load |=> BANK_STATUS != $past(BANK_STATUS);
	endproperty
	a_bank: assert property (p_bank) // RL13
		else $error("bank did not switch");
endmodule

// [tb/tdc_host_model.sv]
// host model: takes decoded receive bits over valid/ready
`timescale 1ns/1ps
module tdc_host_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// decoded bit from the device
	input  wire logic       bit_in,
	input  wire logic       valid,
	output logic            ready,
	// stall control and record of taken bits
	input  wire logic       stall,
	output logic [7:0]      got,
	output logic [7:0]      cnt
);
	logic       ready_q;
	logic [7:0] got_q;
	logic [7:0] cnt_q;

	// ready moves just after an edge; a stall leaves words in the device
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_q <= 1'b0;
			got_q <= 8'h00;
			cnt_q <= 8'h00;
		end else begin
			ready_q <= !stall;
			if (valid && ready_q) begin
				got_q <= {got_q[6:0], bit_in};
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	// outputs
	assign ready = ready_q;
	assign got = got_q;
	assign cnt = cnt_q;
endmodule

// [tb/tdc_top_tb.sv]
// testbench of the transceiver digital control
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tdc_top_tb;
	import tdc_pkg::*;
	// manchester half-bit in clocks at rate 3, band bit 0 low
	localparam int HB = int'(HALF_BIT_R3) * DIV_DIG_B0;
	// half-bit in clocks at rate 2, band bit 0 low
	localparam int HB2 = int'(HALF_BIT_R2) * DIV_DIG_B0;
	logic        clock = 1'b0;
	logic        resetn, lv_en, stby, tx_req, lv_rd, a_en, b_en, sw_cmd;
	logic        direct, lv_cmp, lock, shaped, txd, wake, stall, rdy;
	logic [1:0]  band, lna, pa_st, lpf;
	logic [7:0]  dev, got, cnt;
	logic [15:0] synth;
	logic        rx_bit, rx_vld, rx_clk, rx_ovr, rx_raw, lv_st, mon, sby;
	logic        bank, rfsw, pa_on, thr, dclk, gclk, ifref;
	tdc_cfg_t    cfg_a, cfg_b;
	tdc_direct_t dwords;
	int          failures = 0, cmp_count = 0, ovr_n = 0, clk_n = 0;

	always #(CLK_PERIOD_NS / 2) clock = ~clock;

	tdc_top i_dut (
		.CLOCK(clock), .RESETN(resetn), .LOWVOLT_MONITOR_ENABLE(lv_en),
		.STANDBY_REQ(stby), .TX_REQ(tx_req), .LOWVOLT_READ(lv_rd),
		.BAND_SELECT_BITS(band), .CFG_BANK_A(cfg_a), .CFG_BANK_B(cfg_b),
		.BANK_A_EN(a_en), .BANK_B_EN(b_en), .BANK_SWITCH_CMD(sw_cmd),
		.DIRECT_METHOD(direct), .DEVIATION_WORD(dev), .DIRECT_WORDS(dwords),
		.LOWVOLT_CMP(lv_cmp), .PLL_LOCK(lock), .RX_SHAPED(shaped),
		.TX_DATA(txd), .WAKEUP_STROBE(wake), .RX_BIT_READY(rdy),
		.RX_BIT(rx_bit), .RX_BIT_VALID(rx_vld), .RX_BIT_CLK(rx_clk),
		.RX_OVERRUN(rx_ovr), .RX_RAW(rx_raw), .LOWVOLT_STATUS(lv_st),
		.MONITOR_MODE(mon), .STANDBY_ACTIVE(sby), .BANK_STATUS(bank),
		.RF_SWITCH(rfsw), .PA_ON(pa_on), .SYNTH_WORD(synth), .LNA_STEP(lna),
		.PA_STEP(pa_st), .LPF_BW(lpf), .THRESH_ADAPTIVE(thr),
		.DATA_CLK_EN(dclk), .DIG_CLK_EN(gclk), .IF_REF_TOGGLE(ifref)
	);

	tdc_host_model i_host (
		.clk(clock), .rst_n(resetn), .bit_in(rx_bit), .valid(rx_vld),
		.ready(rdy), .stall(stall), .got(got), .cnt(cnt)
	);

	// one-cycle pulses counted once each, sampled where they have settled
	always @(negedge clock) begin
		if (rx_ovr === 1'b1) ovr_n++;
		if (rx_clk === 1'b1) clk_n++;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask

	// each toggle is a mid-bit edge, so bits alternate 1,0,1,...
	task automatic man(input int n);
		repeat (n) begin
			shaped = ~shaped;
			tick(2 * HB);
		end
	endtask

	// first pass syncs to an event, second measures the spacing
	task automatic gap(input int sel, output int n);
		logic p;
		logic hit;
		p = ifref;
		for (int r = 0; r < 2; r++) begin
			n = 0;
			do begin
				tick(1);
				n++;
				hit = sel == 0 ? dclk === 1'b1 :
					sel == 1 ? gclk === 1'b1 : ifref !== p;
				p = ifref;
			end while (!hit && n < 200);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// cut a hang short, well past the expected run length
	initial begin
		#(CLK_PERIOD_NS * 40000);
		failures++;
		give_verdict();
	end

	initial begin
		int n;
		{resetn, lv_en, stby, tx_req, lv_rd, band, a_en, b_en} = '0;
		{sw_cmd, direct, lv_cmp, lock, shaped, txd, wake, stall} = '0;
		dev = 8'h20;
		dwords = '{16'h1111, 16'h2222, 16'h3333};
		cfg_a = '{1'b0, 1'b0, 2'h3, 2'h3, 2'h1, 2'h2, 1'b1, 16'h4000};
		cfg_b = '{1'b1, 1'b1, 2'h3, 2'h1, 2'h2, 2'h3, 1'b0, 16'h5000};
		tick(3);
		`CHK("rst lvst", 1'b0, lv_st)
		`CHK("rst synth", 16'h0000, synth)
		resetn = 1'b1;
		tick(2);
		// low-voltage flag: set, read while set, latch, clear, disabled
		lv_en = 1'b1;
		lv_cmp = 1'b1;
		tick(8);
		`CHK("lv set", 1'b1, lv_st)
		pulse(lv_rd);
		`CHK("lv rd hold", 1'b1, lv_st)
		lv_cmp = 1'b0;
		tick(8);
		`CHK("lv latch", 1'b1, lv_st)
		pulse(lv_rd);
		`CHK("lv clear", 1'b0, lv_st)
		lv_en = 1'b0;
		lv_cmp = 1'b1;
		tick(8);
		`CHK("lv off", 1'b0, lv_st)
		lv_cmp = 1'b0;
		// standby refused while monitoring, config kept in standby
		lv_en = 1'b1;
		stby = 1'b1;
		tick(2);
		`CHK("mon", 1'b1, mon)
		`CHK("no sby", 1'b0, sby)
		lv_en = 1'b0;
		tick(2);
		`CHK("sby", 1'b1, sby)
		`CHK("sby lna", 2'h1, lna)
		stby = 1'b0;
		// raw shaped data, gated by lock
		lock = 1'b1;
		shaped = 1'b1;
		tick(6);
		`CHK("raw 1", 1'b1, rx_raw)
		`CHK("lna a", 2'h1, lna)
		`CHK("pa a", 2'h2, pa_st)
		`CHK("lpf a", 2'h3, lpf)
		`CHK("thr a", 1'b1, thr)
		shaped = 1'b0;
		tick(6);
		`CHK("raw 0", 1'b0, rx_raw)
		shaped = 1'b1;
		lock = 1'b0;
		tick(6);
		`CHK("raw unlock", 1'b0, rx_raw)
		shaped = 1'b0;
		lock = 1'b1;
		// amplitude keying, switch toggles, lock loss stops carrier
		txd = 1'b1;
		tx_req = 1'b1;
		tick(8);
		`CHK("sw tx", 1'b1, rfsw)
		`CHK("ook on", 1'b1, pa_on)
		`CHK("ook word", 16'h4000, synth)
		txd = 1'b0;
		tick(8);
		`CHK("ook off", 1'b0, pa_on)
		txd = 1'b1;
		lock = 1'b0;
		tick(8);
		`CHK("unlock pa", 1'b0, pa_on)
		lock = 1'b1;
		tx_req = 1'b0;
		tick(3);
		`CHK("sw rx", 1'b0, rfsw)
		// bank B by command: steps and forced adaptive threshold
		a_en = 1'b1;
		b_en = 1'b1;
		pulse(sw_cmd);
		tick(2);
		`CHK("bank b", 1'b1, bank)
		`CHK("lna b", 2'h2, lna)
		`CHK("pa b", 2'h3, pa_st)
		`CHK("lpf b", 2'h1, lpf)
		`CHK("thr fsk", 1'b1, thr)
		// frequency keying, friendly then direct words
		tx_req = 1'b1;
		tick(8);
		`CHK("fsk hi", 16'h5020, synth)
		`CHK("fsk pa", 1'b1, pa_on)
		txd = 1'b0;
		tick(8);
		`CHK("fsk lo", 16'h4FE0, synth)
		direct = 1'b1;
		tick(8);
		`CHK("dir lo", 16'h2222, synth)
		txd = 1'b1;
		tick(8);
		`CHK("dir hi", 16'h3333, synth)
		tx_req = 1'b0;
		tick(3);
		`CHK("dir rx", 16'h1111, synth)
		direct = 1'b0;
		tick(3);
		`CHK("frd rx", 16'h5000, synth)
		// wakeup strobe swaps, single bank ignores the command
		wake = 1'b1;
		tick(8);
		`CHK("wake", 1'b0, bank)
		wake = 1'b0;
		b_en = 1'b0;
		pulse(sw_cmd);
		`CHK("one bank", 1'b0, bank)
		b_en = 1'b1;
		pulse(sw_cmd);
		tick(2);
		`CHK("bank b2", 1'b1, bank)
		// manchester: host stalls, buffer of two, rest overruns
		stall = 1'b1;
		tick(4 * HB);
		man(4);
		`CHK("held", 1'b1, rx_vld)
		`CHK("overrun", 2, ovr_n)
		stall = 1'b0;
		tick(6);
		`CHK("pop cnt", 8'h02, cnt)
		`CHK("pop bits", 2'b10, got[1:0])
		man(2);
		tick(6);
		`CHK("run cnt", 8'h04, cnt)
		`CHK("run bits", 4'hA, got[3:0])
		`CHK("bit clks", 4, clk_n)
		lock = 1'b0;
		man(2);
		`CHK("unlock drop", 8'h04, cnt)
		// rate 2, fixed threshold: bits 1,1,0 with a boundary edge that a
		// wrong rate would take for data
		lock = 1'b1;
		cfg_b.rate = 2'h2;
		cfg_b.freq_shift_mode = 1'b0;
		tick(2 * HB2);
		`CHK("thr fixed", 1'b0, thr)
		shaped = 1'b1;
		tick(HB2);
		shaped = 1'b0;
		tick(HB2);
		shaped = 1'b1;
		tick(2 * HB2);
		shaped = 1'b0;
		tick(2 * HB2);
		`CHK("rate2 cnt", 8'h07, cnt)
		`CHK("rate2 bits", 3'b110, got[2:0])
		// divider spacing for both band settings
		for (int b = 0; b < 2; b++) begin
			band = b[1:0];
			tick(200);
			gap(0, n);
			`CHK("data div", b ? DIV_DATA_B1 : DIV_DATA_B0, n)
			gap(1, n);
			`CHK("dig div", b ? DIV_DIG_B1 : DIV_DIG_B0, n)
			gap(2, n);
			`CHK("if div", b ? DIV_IF_B1 : DIV_IF_B0, n)
		end
		give_verdict();
	end
endmodule
